// ===== shared/sad_pkg.sv
package sad_pkg;

  // ==========================================================
  // Widths
  localparam int SYL_W        = 12;
  localparam int WORD_W       = 48;
  localparam int ADDR_W       = 16;
  localparam int SYL_PER_WORD = 4;
  localparam int NUM_IDX      = 15;
  localparam int IDX_SEL_W    = 4;
  localparam int NUM_SLOTS    = 3;
  localparam int CHAR_W       = 6;
  localparam int RINC_W       = 4;
  localparam int REG_A_W      = 6;

  // ==========================================================
  // Operator syllable fields
  localparam int OP_CODE_W   = 6;
  localparam int OP_CODE_LSB = 6;
  localparam int AC_W        = 2;

  // Address codes
  localparam logic [1:0] AC_STACK   = 2'h0;
  localparam logic [1:0] AC_HOLD    = 2'h1;
  localparam logic [1:0] AC_PLAIN   = 2'h2;
  localparam logic [1:0] AC_INDEXED = 2'h3;

  // ==========================================================
  // Memory syllable and indirect word fields
  localparam int MEM_IND_BIT  = 11;
  localparam int MEM_REL_W    = 11;
  localparam int IND_FLAG_BIT = 16;

  // ==========================================================
  // Operation codes that change syllable meaning
  localparam logic [5:0] OPC_BRANCH = 6'h0A;
  localparam logic [5:0] OPC_SRJ    = 6'h0B;
  localparam logic [5:0] OPC_RPT    = 6'h0C;
  localparam logic [5:0] OPC_CSE    = 6'h0D;

  // ==========================================================
  // Register port offsets
  localparam logic [5:0] RA_DATA_BASE  = 6'h00;
  localparam logic [5:0] RA_PROG_BASE  = 6'h01;
  localparam logic [5:0] RA_SUB_BASE   = 6'h02;
  localparam logic [5:0] RA_PROG_COUNT = 6'h03;
  localparam logic [5:0] RA_STATUS     = 6'h04;
  localparam logic [5:0] RA_REP_LEFT   = 6'h05;
  localparam logic [5:0] RA_INDEX_LO   = 6'h10;
  localparam logic [15:0] RST_ADDR     = 16'h0000;

  // ==========================================================
  // Carriers
  typedef enum logic [2:0] {
    RK_STACK, RK_HOLD, RK_MEMORY, RK_BRANCH, RK_SUBR, RK_INCR, RK_CHAR, RK_COUNT
  } sad_kind_t;

  typedef struct packed {
    sad_kind_t         kind;
    logic [1:0]        slot;
    logic [ADDR_W-1:0] addr;
    logic [SYL_W-1:0]  syl;
  } sad_result_t;

  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] addr;
  } sad_mem_req_t;

endpackage

// ===== hw/sad_syllable_unpacker.sv
`timescale 1ns/1ps
module sad_syllable_unpacker import sad_pkg::*; #(
  parameter int SYL_N = SYL_PER_WORD
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Word side
  input  wire logic              word_valid_i,
  input  wire logic [WORD_W-1:0] word_i,
  output logic                   word_ready_o,
  // Syllable side
  output logic                   syl_valid_o,
  output logic [SYL_W-1:0]       syl_o,
  input  wire logic              take_i,
  input  wire logic              flush_i
);
  localparam int PW = (SYL_N > 1) ? $clog2(SYL_N) : 1;
  localparam logic [PW-1:0] LAST = PW'(SYL_N - 1);

  if (SYL_N * SYL_W != WORD_W) begin : g_chk
    $error("syllables must fill the word exactly");
  end

  logic [WORD_W-1:0] word_reg;
  logic [PW-1:0]     pos_reg;
  logic              full_reg;

  // =====================================================
  // First syllable sits in the high end of the word
  assign syl_o        = word_reg[WORD_W - 1 - int'(pos_reg) * SYL_W -: SYL_W];
  assign syl_valid_o  = full_reg;
  // A word arriving during a flush belongs to the old stream
  assign word_ready_o = !flush_i && (!full_reg || (take_i && pos_reg == LAST));

  // Word holding and syllable position
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_reg <= '0;
      pos_reg  <= '0;
      full_reg <= 1'b0;
    end else if (ce_i) begin
      if (flush_i) begin
        full_reg <= 1'b0;
        pos_reg  <= '0;
      end else if (word_ready_o && word_valid_i) begin
        word_reg <= word_i;
        pos_reg  <= '0;
        full_reg <= 1'b1;
      end else if (take_i && full_reg) begin
        if (pos_reg == LAST) begin
          full_reg <= 1'b0;
        end else begin
          pos_reg <= pos_reg + PW'(1);
        end
      end
    end
  end
endmodule

// ===== hw/sad_index_file.sv
`timescale 1ns/1ps
module sad_index_file import sad_pkg::*; #(
  parameter int N = NUM_IDX
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  // Write port
  input  wire logic                          we_i,
  input  wire logic [IDX_SEL_W-1:0]          wsel_i,
  input  wire logic [ADDR_W-1:0]             wdata_i,
  // Read ports
  input  wire logic [NUM_SLOTS-1:0][IDX_SEL_W-1:0] sel_i,
  output logic [NUM_SLOTS-1:0][ADDR_W-1:0]   val_o,
  input  wire logic [IDX_SEL_W-1:0]          bus_sel_i,
  output logic [ADDR_W-1:0]                  bus_val_o
);
  if (N < 1 || N >= (1 << IDX_SEL_W)) begin : g_chk
    $error("index count does not fit the selector field");
  end

  logic [ADDR_W-1:0] idx_reg [1:N];

  // Selector zero names no register and adds nothing
  function automatic logic [ADDR_W-1:0] pick(input logic [IDX_SEL_W-1:0] s);
    logic [ADDR_W-1:0] v;
    v = '0;
    if (s != '0 && int'(s) <= N) begin
      v = idx_reg[int'(s)];
    end
    return v;
  endfunction

  // =====================================================
  // Read ports
  for (genvar k = 0; k < NUM_SLOTS; k++) begin : g_rd
    assign val_o[k] = pick(sel_i[k]);
  end
  assign bus_val_o = pick(bus_sel_i);

  // Register storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 1; i <= N; i++) begin
        idx_reg[i] <= RST_ADDR;
      end
    end else if (ce_i && we_i && wsel_i != '0 && int'(wsel_i) <= N) begin
      idx_reg[int'(wsel_i)] <= wdata_i;
    end
  end
endmodule

// ===== hw/sad_syllable_decoder.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Address codes: stack, hold, plain, indexed.
// - Add up to three index registers.
// - Selector zero adds nothing.
// - Index syllable modifies only the next syllable.
// - Index sum added after indirect chain ends.
// - Memory address is relative plus data base.
// - Indirect word gives address and next flag.
// - Later levels are absolute, no base added.
// - Follow chain until flag reads zero.
// - Indirect address low sixteen, flag above.
// - Omitted memory syllable means the stack.
// - Branch target is relative plus program base.
// - Every branch loads the program count; here only with a plain or indexed slot 0.
// - Subroutine entry is relative plus subroutine base.
// - Subroutine jump bumps data base by increment.
// - Repeat passes, incrementing syllables two to four.
// - Character syllable gives six-bit search value.
// - Every syllable is twelve bits.
// - Eleven low bits form relative address; branch and subroutine targets here add all twelve bits of the syllable.
module sad_syllable_decoder import sad_pkg::*; #(
  parameter int N_IDX = NUM_IDX
) (
  // Clock, reset, enable
  input  wire logic              CLOCK_I,
  input  wire logic              RST_I,
  input  wire logic              CE_I,
  // Program words from the fetch sequencer
  input  wire logic              WORD_VALID_I,
  input  wire logic [WORD_W-1:0] WORD_I,
  output logic                   WORD_READY_O,
  output logic                   JUMP_O,
  output logic [ADDR_W-1:0]      PROG_COUNT_O,
  // Main memory read for indirect levels
  output sad_mem_req_t           MEM_REQ_O,
  input  wire logic              MEM_ACK_I,
  input  wire logic [WORD_W-1:0] MEM_DATA_I,
  // Decoded results
  output logic                   OP_VALID_O,
  output logic [OP_CODE_W-1:0]   OP_CODE_O,
  output logic                   RES_VALID_O,
  output sad_result_t            RES_O,
  output logic                   DONE_O,
  // Register port
  input  wire logic [REG_A_W-1:0] REG_ADDR_I,
  input  wire logic [ADDR_W-1:0] REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic [ADDR_W-1:0]      REG_RDATA_O
);

  // =====================================================
  // Declarations
  typedef enum logic [2:0] {
    S_OPER, S_SLOT, S_XSYL, S_FETCH, S_IND, S_DONE
  } sad_state_t;

  sad_state_t state_reg;
  logic [OP_CODE_W-1:0] op_reg;
  logic [NUM_SLOTS-1:0][AC_W-1:0] code_reg;
  logic [1:0] slot_reg;
  logic [NUM_SLOTS-1:0][IDX_SEL_W-1:0] sel_reg;
  logic [ADDR_W-1:0] chain_reg;
  logic [ADDR_W-1:0] data_base_reg, program_base_reg, subroutine_base_reg;
  logic [ADDR_W-1:0] program_count_reg, sub_target_reg;
  logic rep_armed_reg, rep_active_reg, replay_reg;
  logic [SYL_W-1:0] rep_left_reg, rep_count_reg, rep_inc_reg;
  logic [NUM_SLOTS-1:0][SYL_W-1:0] rep_syl_reg;
  logic res_valid_reg, op_valid_reg, done_reg, jump_reg;
  sad_result_t res_reg;
  logic [ADDR_W-1:0] rdata_reg;

  logic u_valid, take, flush;
  logic [SYL_W-1:0] u_syl, syl;
  logic syl_ok;
  logic [NUM_SLOTS-1:0][ADDR_W-1:0] idx_val;
  logic [ADDR_W-1:0] idx_sum, bus_idx_val, mem_ea, fin_addr;
  logic [AC_W-1:0] cur_code;
  logic is_branch, is_srj, is_rpt, is_cse;
  logic [REG_A_W-1:0] idx_off;
  logic idx_we;

  // Address code of an operator slot; slot 0 is the first address
  function automatic logic [AC_W-1:0] slot_code(input logic [SYL_W-1:0] s, input int k);
    return s[(NUM_SLOTS - 1 - k) * AC_W +: AC_W];
  endfunction

  // Repeat amount for one slot, slot 0 being the second syllable
  function automatic logic [SYL_W-1:0] rep_amt(input logic [SYL_W-1:0] s, input int k);
    return SYL_W'(s[(NUM_SLOTS - 1 - k) * RINC_W +: RINC_W]);
  endfunction

  if (NUM_SLOTS * RINC_W > SYL_W || NUM_SLOTS * AC_W + OP_CODE_W > SYL_W) begin : g_chk
    $error("syllable fields overflow the syllable width");
  end

  // =====================================================
  // Submodules
  sad_syllable_unpacker #(.SYL_N(SYL_PER_WORD)) u_unpack (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .ce_i         (CE_I),
    .word_valid_i (WORD_VALID_I),
    .word_i       (WORD_I),
    .word_ready_o (WORD_READY_O),
    .syl_valid_o  (u_valid),
    .syl_o        (u_syl),
    .take_i       (take),
    .flush_i      (flush)
  );

  assign idx_off = REG_ADDR_I - RA_INDEX_LO;
  assign idx_we  = REG_WR_I && idx_off[REG_A_W-1:IDX_SEL_W] == '0;

  sad_index_file #(.N(N_IDX)) u_index (
    .clk_i     (CLOCK_I),
    .rst_i     (RST_I),
    .ce_i      (CE_I),
    .we_i      (idx_we),
    .wsel_i    (idx_off[IDX_SEL_W-1:0]),
    .wdata_i   (REG_WDATA_I),
    .sel_i     (sel_reg),
    .val_o     (idx_val),
    .bus_sel_i (idx_off[IDX_SEL_W-1:0]),
    .bus_val_o (bus_idx_val)
  );

  // =====================================================
  // Combinational decode
  // Replayed passes read the stored, incremented syllables
  assign syl    = replay_reg ? rep_syl_reg[slot_reg] : u_syl;
  assign syl_ok = replay_reg || (u_valid && !flush); // No stale syllable on jump
  assign cur_code  = code_reg[slot_reg];
  assign is_branch = op_reg == OPC_BRANCH;
  assign is_srj    = op_reg == OPC_SRJ;
  assign is_rpt    = op_reg == OPC_RPT;
  assign is_cse    = op_reg == OPC_CSE;
  // Wraps modulo 2^16, so a stored two's complement subtracts
  assign idx_sum   = idx_val[0] + idx_val[1] + idx_val[2];
  assign mem_ea    = data_base_reg + ADDR_W'(syl[MEM_REL_W-1:0]);
  assign fin_addr  = chain_reg + idx_sum;

  // Syllable consumption from the unpacker
  always_comb begin
    take = 1'b0;
    if (!replay_reg && syl_ok) begin
      unique case (state_reg)
        S_OPER, S_XSYL, S_FETCH: take = 1'b1;
        default: take = 1'b0;
      endcase
    end
  end

  // Any jump discards the rest of the current program word
  assign flush = jump_reg;

  // =====================================================
  // Sequencing
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= S_OPER;
      op_reg    <= '0;
      code_reg  <= '0;
      slot_reg  <= '0;
      sel_reg   <= '0;
      chain_reg <= RST_ADDR;
    end else if (CE_I) begin
      unique case (state_reg)
        S_OPER: if (syl_ok) begin
          op_reg   <= syl[OP_CODE_LSB +: OP_CODE_W];
          for (int k = 0; k < NUM_SLOTS; k++) begin
            code_reg[k] <= slot_code(syl, k);
          end
          slot_reg  <= '0;
          state_reg <= S_SLOT;
        end
        S_SLOT: begin
          sel_reg <= '0;
          if (int'(slot_reg) == NUM_SLOTS) begin
            state_reg <= S_DONE;
          end else if (cur_code == AC_STACK || cur_code == AC_HOLD) begin
            slot_reg <= slot_reg + 2'h1;
          end else if (cur_code == AC_INDEXED && !replay_reg) begin
            state_reg <= S_XSYL;
          end else begin
            state_reg <= S_FETCH;
          end
        end
        S_XSYL: if (syl_ok) begin
          // Selectors live only until the next syllable finishes
          for (int k = 0; k < NUM_SLOTS; k++) begin
            sel_reg[k] <= syl[(NUM_SLOTS - 1 - k) * IDX_SEL_W +: IDX_SEL_W];
          end
          state_reg <= S_FETCH;
        end
        S_FETCH: if (syl_ok) begin
          chain_reg <= mem_ea;
          if ((is_branch && slot_reg == 2'h0) || (is_srj && slot_reg == 2'h1)) begin
            state_reg <= S_OPER;
          end else if (!(is_branch || is_srj || is_rpt || is_cse) && syl[MEM_IND_BIT]) begin
            state_reg <= S_IND;
          end else begin
            slot_reg  <= slot_reg + 2'h1;
            state_reg <= S_SLOT;
          end
        end
        S_IND: if (MEM_ACK_I) begin
          // Later levels are absolute; no base is added
          chain_reg <= MEM_DATA_I[ADDR_W-1:0];
          if (!MEM_DATA_I[IND_FLAG_BIT]) begin
            slot_reg  <= slot_reg + 2'h1;
            state_reg <= S_SLOT;
          end
        end
        S_DONE: begin
          slot_reg  <= '0;
          state_reg <= (rep_active_reg && rep_left_reg > SYL_W'(1)) ? S_SLOT : S_OPER;
        end
      endcase
    end
  end

  // =====================================================
  // Result emission
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      res_valid_reg <= 1'b0;
      res_reg       <= '0;
      op_valid_reg  <= 1'b0;
      done_reg      <= 1'b0;
    end else if (CE_I) begin
      res_valid_reg  <= 1'b0;
      op_valid_reg   <= 1'b0;
      done_reg       <= 1'b0;
      res_reg.slot   <= slot_reg;
      res_reg.syl    <= syl;
      if (state_reg == S_OPER && syl_ok) begin
        op_valid_reg <= 1'b1;
      end
      if (state_reg == S_DONE) begin
        done_reg <= 1'b1;
      end
      if (state_reg == S_SLOT && int'(slot_reg) < NUM_SLOTS
          && (cur_code == AC_STACK || cur_code == AC_HOLD)) begin
        res_valid_reg <= 1'b1;
        res_reg.kind  <= (cur_code == AC_STACK) ? RK_STACK : RK_HOLD;
        res_reg.addr  <= RST_ADDR;
      end
      if (state_reg == S_FETCH && syl_ok) begin
        res_valid_reg <= !(syl[MEM_IND_BIT] && !(is_branch || is_srj || is_rpt || is_cse));
        if (is_branch && slot_reg == 2'h0) begin
          res_reg.kind <= RK_BRANCH;
          res_reg.addr <= program_base_reg + ADDR_W'(syl) + idx_sum;
        end else if (is_srj && slot_reg == 2'h0) begin
          res_reg.kind <= RK_SUBR;
          res_reg.addr <= subroutine_base_reg + ADDR_W'(syl) + idx_sum;
        end else if (is_srj) begin
          res_reg.kind <= RK_INCR;
          res_reg.addr <= ADDR_W'(syl) + idx_sum;
        end else if (is_rpt) begin
          res_reg.kind <= RK_COUNT;
          res_reg.addr <= ADDR_W'(syl);
        end else if (is_cse && slot_reg == 2'h0) begin
          res_reg.kind <= RK_CHAR;
          res_reg.addr <= ADDR_W'(syl[CHAR_W-1:0]);
        end else begin
          res_reg.kind <= RK_MEMORY;
          res_reg.addr <= mem_ea + idx_sum;
        end
      end
      if (state_reg == S_IND && MEM_ACK_I && !MEM_DATA_I[IND_FLAG_BIT]) begin
        res_valid_reg <= 1'b1;
        res_reg.kind  <= RK_MEMORY;
        res_reg.addr  <= MEM_DATA_I[ADDR_W-1:0] + idx_sum;
      end
    end
  end

  // =====================================================
  // Base registers, program count and jumps
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      data_base_reg       <= RST_ADDR;
      program_base_reg    <= RST_ADDR;
      subroutine_base_reg <= RST_ADDR;
      program_count_reg   <= RST_ADDR;
      sub_target_reg      <= RST_ADDR;
      jump_reg            <= 1'b0;
    end else if (CE_I) begin
      jump_reg <= 1'b0;
      if (REG_WR_I) begin
        unique case (REG_ADDR_I)
          RA_DATA_BASE:  data_base_reg       <= REG_WDATA_I;
          RA_PROG_BASE:  program_base_reg    <= REG_WDATA_I;
          RA_SUB_BASE:   subroutine_base_reg <= REG_WDATA_I;
          RA_PROG_COUNT: program_count_reg   <= REG_WDATA_I;
          default: ;
        endcase
      end
      // Decoder updates win over a same-cycle software write
      if (state_reg == S_FETCH && syl_ok) begin
        if (is_branch && slot_reg == 2'h0) begin
          program_count_reg <= program_base_reg + ADDR_W'(syl) + idx_sum;
          jump_reg          <= 1'b1;
        end else if (is_srj && slot_reg == 2'h0) begin
          sub_target_reg <= subroutine_base_reg + ADDR_W'(syl) + idx_sum;
        end else if (is_srj) begin
          data_base_reg     <= data_base_reg + ADDR_W'(syl) + idx_sum;
          program_count_reg <= sub_target_reg;
          jump_reg          <= 1'b1;
        end
      end
    end
  end

  // =====================================================
  // Repeat control
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rep_armed_reg  <= 1'b0;
      rep_active_reg <= 1'b0;
      replay_reg     <= 1'b0;
      rep_left_reg   <= '0;
      rep_count_reg  <= '0;
      rep_inc_reg    <= '0;
      rep_syl_reg    <= '0;
    end else if (CE_I) begin
      if (state_reg == S_FETCH && syl_ok && is_rpt) begin
        if (slot_reg == 2'h0) begin
          rep_count_reg <= syl;
        end else begin
          rep_inc_reg <= syl;
        end
      end
      if (state_reg == S_OPER && syl_ok) begin
        rep_active_reg <= rep_armed_reg;
        rep_armed_reg  <= 1'b0;
        rep_left_reg   <= rep_count_reg;
      end
      // Keep the repeated instruction's syllables for later passes
      if (rep_active_reg && !replay_reg && state_reg == S_FETCH && syl_ok) begin
        rep_syl_reg[slot_reg] <= syl;
      end
      if (state_reg == S_DONE) begin
        if (rep_active_reg && rep_left_reg > SYL_W'(1)) begin
          rep_left_reg <= rep_left_reg - SYL_W'(1);
          replay_reg   <= 1'b1;
          for (int k = 0; k < NUM_SLOTS; k++) begin
            rep_syl_reg[k] <= rep_syl_reg[k] + rep_amt(rep_inc_reg, k);
          end
        end else begin
          rep_active_reg <= 1'b0;
          replay_reg     <= 1'b0;
          rep_armed_reg  <= is_rpt;
        end
      end
    end
  end

  // =====================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= '0;
    end else if (CE_I) begin
      rdata_reg <= '0;
      if (REG_RD_I) begin
        unique case (REG_ADDR_I)
          RA_DATA_BASE:  rdata_reg <= data_base_reg;
          RA_PROG_BASE:  rdata_reg <= program_base_reg;
          RA_SUB_BASE:   rdata_reg <= subroutine_base_reg;
          RA_PROG_COUNT: rdata_reg <= program_count_reg;
          RA_STATUS:     rdata_reg <= {ADDR_W'(state_reg)} | {rep_active_reg, 15'h0000};
          RA_REP_LEFT:   rdata_reg <= ADDR_W'(rep_left_reg);
          default:       rdata_reg <= (idx_off[REG_A_W-1:IDX_SEL_W] == '0) ? bus_idx_val : '0;
        endcase
      end
    end
  end

  // =====================================================
  // Outputs
  assign MEM_REQ_O.rd   = state_reg == S_IND;
  assign MEM_REQ_O.addr = chain_reg;
  assign JUMP_O         = jump_reg;
  assign PROG_COUNT_O   = program_count_reg;
  assign OP_VALID_O     = op_valid_reg;
  assign OP_CODE_O      = op_reg;
  assign RES_VALID_O    = res_valid_reg;
  assign RES_O          = res_reg;
  assign DONE_O         = done_reg;
  assign REG_RDATA_O    = rdata_reg;

endmodule

// ===== dv/sad_decoder_assertions.sv
`timescale 1ns/1ps
module sad_dec_chk import sad_pkg::*; #(parameter int N_IDX = NUM_IDX) (
  // Watched ports
  input wire logic         CLOCK_I, RST_I, WORD_READY_O, JUMP_O, MEM_ACK_I,
  input wire logic         RES_VALID_O, REG_RD_I,
  input wire logic [15:0]  PROG_COUNT_O, REG_RDATA_O,
  input wire logic [5:0]   REG_ADDR_I,
  input wire logic [47:0]  MEM_DATA_I,
  input wire sad_mem_req_t MEM_REQ_O,
  input wire sad_result_t  RES_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  logic        rd_q;
  logic [5:0]  ra_q;
  logic [15:0] pc_q, ch_q, tg_q, tg_c;
  // Jump target, usable in the very cycle it is reported
  assign tg_c = (RES_VALID_O && RES_O.kind inside {RK_BRANCH, RK_SUBR}) ? RES_O.addr : tg_q;
  // Context of reads and indirect words; no reset, every edge refreshes it except ch_q, which loads only on an acknowledge
  always_ff @(posedge CLOCK_I) begin
    rd_q <= REG_RD_I;
    ra_q <= REG_ADDR_I;
    pc_q <= PROG_COUNT_O;
    tg_q <= tg_c;
    if (MEM_ACK_I) ch_q <= MEM_DATA_I[15:0];
  end
  // ==========
  // Checks
  no_word_jump_a: assert property (JUMP_O |-> !WORD_READY_O)
    else $error("word accepted during jump");
  branch_jump_a: assert property (RES_VALID_O && RES_O.kind == RK_BRANCH |-> ##[0:2] JUMP_O)
    else $error("branch without jump");
  jump_target_a: assert property (JUMP_O |-> PROG_COUNT_O == tg_c)
    else $error("program count not at target");
  jump_once_a: assert property (JUMP_O |=> !JUMP_O)
    else $error("jump pulse too long");
  req_held_a: assert property (MEM_REQ_O.rd && !MEM_ACK_I |=> MEM_REQ_O.rd && $stable(MEM_REQ_O.addr))
    else $error("memory request dropped");
  chain_next_a: assert property (MEM_REQ_O.rd && MEM_ACK_I && MEM_DATA_I[16]
    |=> ##[0:3] (MEM_REQ_O.rd && MEM_REQ_O.addr == ch_q))
    else $error("chain level not absolute");
  chain_end_a: assert property (MEM_REQ_O.rd && MEM_ACK_I && !MEM_DATA_I[16]
    |=> RES_VALID_O && RES_O.kind == RK_MEMORY)
    else $error("chain end not reported");
  pc_read_a: assert property (rd_q && ra_q == RA_PROG_COUNT |-> REG_RDATA_O == pc_q)
    else $error("program count read wrong");
  cover property (JUMP_O);
  cover property (MEM_ACK_I && MEM_DATA_I[16]);
  cover property (rd_q && ra_q == RA_PROG_COUNT);
endmodule
bind sad_syllable_decoder sad_dec_chk #(.N_IDX(N_IDX)) chk_u (.CLOCK_I, .RST_I, .WORD_READY_O,
  .JUMP_O, .MEM_ACK_I, .RES_VALID_O, .REG_RD_I, .PROG_COUNT_O, .REG_RDATA_O, .REG_ADDR_I,
  .MEM_DATA_I, .MEM_REQ_O, .RES_O);

// ===== dv/sad_mem_model.sv
`timescale 1ns/1ps
module sad_mem_model import sad_pkg::*; (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Memory read port
  input  wire sad_mem_req_t req_i,
  output logic              ack_o,
  output logic [WORD_W-1:0] data_o
);
  logic [1:0] wait_q;
  logic       slow_q;
  // Prompt and slow answers by turns; junk on the bus when idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o  <= 1'b0;
      data_o <= '0;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
    end else if (req_i.rd && !ack_o && wait_q >= {slow_q, 1'b0}) begin
      ack_o  <= 1'b1;
      wait_q <= 2'h0;
      slow_q <= ~slow_q;
      // Upper bits set so misuse of them shows
      data_o <= {31'h7FFFFFFF, req_i.addr < 16'h2000, req_i.addr + 16'h1111};
    end else begin
      ack_o  <= 1'b0;
      data_o <= ~data_o;
      wait_q <= wait_q + {1'b0, req_i.rd && !ack_o};
    end
  end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top import sad_pkg::*;;
  logic         clk, rst, wvalid, wready, ack, resv, wr, rd;
  logic [47:0]  word, mdata;
  logic [15:0]  wdat, rdat, base, pb, x15, x2, ea;
  logic [11:0]  rel;
  logic [5:0]   radr;
  sad_mem_req_t req;
  sad_result_t  res;
  sad_kind_t    exp_k[$];
  logic [15:0]  exp_a[$];
  int           err_total, n_compared;
  sad_syllable_decoder dut_u (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .WORD_VALID_I(wvalid),
    .WORD_I(word), .WORD_READY_O(wready), .JUMP_O(), .PROG_COUNT_O(), .MEM_REQ_O(req),
    .MEM_ACK_I(ack), .MEM_DATA_I(mdata), .OP_VALID_O(), .OP_CODE_O(), .RES_VALID_O(resv),
    .RES_O(res), .DONE_O(), .REG_ADDR_I(radr), .REG_WDATA_I(wdat), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdat));
  sad_mem_model mem_u (.clk_i(clk), .rst_i(rst), .req_i(req), .ack_o(ack), .data_o(mdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Results are judged mid-cycle, where registered outputs have settled
  always @(negedge clk) begin
    if (resv === 1'b1) begin
      if (exp_k.size() == 0) chk("spare result", 16'h0001, 16'h0000);
      else begin
        chk("result kind", 16'(exp_k[0]), 16'(res.kind));
        if (exp_k[0] != RK_STACK && exp_k[0] != RK_HOLD) chk("result addr", exp_a[0], res.addr);
        exp_k.pop_front();
        exp_a.pop_front();
      end
    end
  end
  task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
    radr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [5:0] a, input logic [15:0] e);
    radr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("register read", e, rdat);
    @(posedge clk);
  endtask
  // Follows the partner's chain: flag set below 2000h, next is addr plus 1111h
  function automatic logic [15:0] walk(input logic [15:0] a);
    logic f;
    do begin
      f = a < 16'h2000;
      a = a + 16'h1111;
    end while (f);
    return a;
  endfunction
  task automatic run_ins(input logic [5:0] opc, input bit ix, input logic [11:0] syl,
                         input sad_kind_t k, input logic [15:0] a, input int nst);
    logic [11:0] op;
    logic        ok;
    int          n;
    op = {opc, ix ? 2'b11 : 2'b10, nst > 0 ? 4'h4 : 4'h0};
    exp_k.push_back(k);
    exp_a.push_back(a);
    for (n = 0; n < nst; n++) begin
      exp_k.push_back(n == 0 ? RK_HOLD : RK_STACK);
      exp_a.push_back(16'h0000);
    end
    // Index syllable right before its target, never before another index
    word <= ix ? {op, 12'hF20, syl, 12'h000} : {op, syl, 24'h000000};
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ok = wready;
      @(posedge clk);
      n++;
    end while (ok !== 1'b1 && n < 200);
    wvalid <= 1'b0;
    n = 0;
    while (exp_k.size() > 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("results left", 16'h0000, 16'(exp_k.size()));
    exp_k.delete();
    exp_a.delete();
    repeat (4) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  // ==========
  // Main sequence
  initial begin
    rst = 1'b1;
    wvalid = 1'b0;
    word = '0;
    wr = 1'b0;
    rd = 1'b0;
    radr = '0;
    wdat = '0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'h683321E9));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    base = 16'($urandom_range(0, 16'h0FFF));
    pb = 16'($urandom);
    x15 = 16'($urandom);
    x2 = 16'($urandom);
    reg_wr(RA_DATA_BASE, base);
    reg_wr(RA_PROG_BASE, pb);
    reg_wr(RA_INDEX_LO + 6'h0F, x15);
    reg_wr(RA_INDEX_LO + 6'h02, x2);
    reg_rd(RA_INDEX_LO + 6'h0F, x15);
    reg_rd(RA_INDEX_LO, 16'h0000);
    reg_rd(6'h3F, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rel = 12'($urandom_range(0, 16'h07FF)) | (i[0] ? 12'h800 : 12'h000);
      ea = base + 16'(rel[10:0]);
      if (rel[11]) ea = walk(ea);
      if (i[1]) ea = ea + x15 + x2;
      run_ins(6'h00, i[1], rel, RK_MEMORY, ea, i[1] ? 5 : 8);
    end
    for (int i = 0; i < 2; i++) begin
      rel = 12'($urandom);
      ea = pb + 16'(rel) + (i[0] ? x15 + x2 : 16'h0000);
      run_ins(OPC_BRANCH, i[0], rel, RK_BRANCH, ea, 0);
      reg_rd(RA_PROG_COUNT, ea);
    end
    tally_and_finish;
  end
endmodule
